// ### verilog/rsv_pkg.sv
// package for the relay state verifier: register map, field layout, mask codes, sizes.
// assumes a single 250 MHz clock domain and an AXI4-Lite master with 32-bit data.
// Behaviour
// - with confidence on, check all relays after every open or close command.
// - confidence failure sets the status fail bit and the execution-error event bit.
// - confidence result is one pass or fail, with no failing relay named.
// - one readback line per relay feeds both verification and confidence checks.
// - each channel mask is normal (0), inverted (1) or ignore (X).
// - every mask starts as ignore until software writes it.
// - a mask write applies one setting to every channel of a range.
// - a mask query returns the stored setting of the one channel written to the query register; during a scan, that of the scanned channel.
// - on-demand verification takes one channel or a range, only while the engine is idle.
// - no unmasked mismatch in the range reports OK.
// - failures report module and channel number of each failing channel, in order.
// - ignored channels never appear in a failure report.
// - a failure report stops after the first ten failing channels.
// - save copies all masks to the store; recall restores them.
// - the auto-recall flag resets to off before the boot cycle, so stored masks never load at power-up.
package rsv_pkg;
	localparam int          NUM_MOD      = 8;
	localparam int          CH_PER_MOD   = 32;
	localparam int          NUM_CH       = NUM_MOD * CH_PER_MOD;
	localparam int          CH_W         = 8;
	localparam int          MAX_FAIL     = 10;
	localparam int          FAIL_W       = 4;
	localparam int          WORDS        = NUM_CH / 32;

	// mask codes, two bits per channel
	localparam logic [1:0]  MASK_NORMAL  = 2'h0;
	localparam logic [1:0]  MASK_INVERT  = 2'h1;
	localparam logic [1:0]  MASK_IGNORE  = 2'h2;

	// register byte offsets
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_STATUS   = 8'h04;
	localparam logic [7:0]  OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0]  OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0]  OFF_RANGE    = 8'h10;
	localparam logic [7:0]  OFF_CMD      = 8'h14;
	localparam logic [7:0]  OFF_FCOUNT   = 8'h18;
	localparam logic [7:0]  OFF_MASKRD   = 8'h1c;
	localparam logic [7:0]  OFF_FAIL0    = 8'h20;
	localparam logic [7:0]  OFF_RELAY0   = 8'h60;

	// ctrl fields
	localparam int          CTRL_CONF    = 0;
	localparam int          CTRL_AUTORCL = 1;
	// cmd fields
	localparam int          CMD_MASKWR   = 0;
	localparam int          CMD_VERIFY   = 1;
	localparam int          CMD_SAVE     = 2;
	localparam int          CMD_RECALL   = 3;
	localparam int          CMD_VAL_LSB  = 4;
	// status fields
	localparam int          ST_BUSY      = 0;
	localparam int          ST_CONF_FAIL = 1;
	localparam int          ST_VERIFY_OK = 2;
	// event bits
	localparam int          EV_EXEC_ERR  = 0;
	localparam int          EV_VER_DONE  = 1;
	localparam int          EV_W         = 2;

	localparam logic [1:0]  AXI_OKAY     = 2'h0;
	localparam logic [1:0]  AXI_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		RSV_IDLE  = 2'b00,
		RSV_SCAN  = 2'b01,
		RSV_DONE  = 2'b11
	} rsv_state_e;

	function automatic logic chan_fails(input logic [1:0] m, input logic rb, input logic cmd);
		chan_fails = (m != MASK_IGNORE) && ((rb ^ (m == MASK_INVERT)) != cmd);
	endfunction
endpackage

// ### verilog/rsv_mask_store.sv
// mask storage: live masks plus a saved copy standing in for non-volatile memory.
// assumes save, recall and writes come from the verifier and never coincide.
`timescale 1ns/1ps
module rsv_mask_store
	import rsv_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              wr_in,
	input  wire logic [CH_W-1:0]   wr_ch_in,
	input  wire logic [1:0]        wr_val_in,
	input  wire logic              save_in,
	input  wire logic              recall_in,
	input  wire logic              auto_recall_in,
	input  wire logic [CH_W-1:0]   rd_ch_in,
	output logic      [1:0]        rd_val_out
);
	logic [1:0] mask_reg  [NUM_CH];
	logic [1:0] saved_reg [NUM_CH];
	logic       boot_reg;

	// saved copy survives reset as a non-volatile store would
	always_ff @(posedge clk_in) begin
		if (save_in) begin
			saved_reg <= mask_reg;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			boot_reg <= 1'b1;
			for (int i = 0; i < NUM_CH; i++) begin
				mask_reg[i] <= MASK_IGNORE;
			end
		end else begin
			boot_reg <= 1'b0;
			if (recall_in || (boot_reg && auto_recall_in)) begin
				mask_reg <= saved_reg;
			end else if (wr_in) begin
				mask_reg[wr_ch_in] <= wr_val_in;
			end
		end
	end

	assign rd_val_out = mask_reg[rd_ch_in];
endmodule

// ### verilog/rsv_fail_log.sv
// failure list: keeps up to ten failing channel numbers in the order found.
// assumes clear precedes each verification run.
`timescale 1ns/1ps
module rsv_fail_log
	import rsv_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              clear_in,
	input  wire logic              push_in,
	input  wire logic [CH_W-1:0]   ch_in,
	input  wire logic [3:0]        rd_idx_in,
	output logic      [FAIL_W-1:0] count_out,
	output logic      [CH_W-1:0]   rd_ch_out
);
	logic [CH_W-1:0]   list_reg [MAX_FAIL];
	logic [FAIL_W-1:0] count_reg;
	wire               room = count_reg < FAIL_W'(MAX_FAIL);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_reg <= '0;
			for (int i = 0; i < MAX_FAIL; i++) begin
				list_reg[i] <= '0;
			end
		end else if (clear_in) begin
			count_reg <= '0;
		end else if (push_in && room) begin
			list_reg[count_reg] <= ch_in;
			count_reg           <= count_reg + 1'b1;
		end
	end

	assign count_out = count_reg;
	assign rd_ch_out = (rd_idx_in < 4'(MAX_FAIL)) ? list_reg[rd_idx_in] : '0;
endmodule

// ### verilog/rsv_top.sv
// relay state verifier: AXI4-Lite registers, mask writes over ranges, on-demand verification
// and confidence checks of relay readback against the commanded relay state.
// assumes relay_cmd_in is the commanded coil state and relay_change_in pulses per open/close.
`timescale 1ns/1ps
module rsv_top
	import rsv_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic [NUM_CH-1:0] relay_cmd_in,
	input  wire logic [NUM_CH-1:0] readback_in,
	input  wire logic              relay_change_in,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   irq_out
);
	// write channel
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        aw_have_reg;
	logic        w_have_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	// read channel
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	// registers
	logic        conf_en_reg;
	logic        auto_rcl_reg;
	logic [EV_W-1:0] ev_stat_reg;
	logic [EV_W-1:0] ev_mask_reg;
	logic [CH_W-1:0] first_reg;
	logic [CH_W-1:0] last_reg;
	logic [CH_W-1:0] mask_rd_ch_reg;
	logic        conf_fail_reg;
	logic        ver_ok_reg;
	// engine
	rsv_state_e  state_reg;
	logic        job_conf_reg;
	logic        job_mask_reg;
	logic [1:0]  job_val_reg;
	logic [CH_W-1:0] ch_reg;
	logic [CH_W-1:0] end_reg;
	logic        any_fail_reg;
	logic        conf_pend_reg;

	wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	wire do_read  = s_axi_arvalid && !rvalid_reg;
	wire word_wr  = do_write && (wstrb_reg == 4'hf);
	wire busy     = (state_reg != RSV_IDLE);

	wire wr_ctrl  = word_wr && (awaddr_reg == OFF_CTRL);
	wire wr_istat = word_wr && (awaddr_reg == OFF_IRQ_STAT);
	wire wr_imask = word_wr && (awaddr_reg == OFF_IRQ_MASK);
	wire wr_range = word_wr && (awaddr_reg == OFF_RANGE) && !busy;
	wire wr_cmd   = word_wr && (awaddr_reg == OFF_CMD) && !busy;
	wire wr_mrd   = word_wr && (awaddr_reg == OFF_MASKRD);
	wire wr_known = (awaddr_reg[7:2] <= OFF_MASKRD[7:2]);

	wire cmd_mask   = wr_cmd && wdata_reg[CMD_MASKWR];
	wire cmd_verify = wr_cmd && wdata_reg[CMD_VERIFY] && !wdata_reg[CMD_MASKWR];
	wire cmd_save   = wr_cmd && wdata_reg[CMD_SAVE];
	wire cmd_recall = wr_cmd && wdata_reg[CMD_RECALL];
	wire [1:0] cmd_val = wdata_reg[CMD_VAL_LSB +: 2];
	wire start_conf = !busy && conf_pend_reg && !wr_cmd;

	// engine walks one channel per cycle; range may count down as well as up
	wire [CH_W-1:0] step_ch = (ch_reg <= end_reg) ? ch_reg + 1'b1 : ch_reg - 1'b1;
	wire            at_end  = (ch_reg == end_reg);
	wire [CH_W-1:0] sel_ch  = (state_reg == RSV_SCAN) ? ch_reg : mask_rd_ch_reg;
	wire [1:0]      sel_mask;
	wire            scan    = (state_reg == RSV_SCAN);
	wire            ch_bad  = scan && !job_mask_reg &&
	                          chan_fails(sel_mask, readback_in[ch_reg], relay_cmd_in[ch_reg]);
	wire            finish  = scan && at_end;
	wire            conf_bad = finish && job_conf_reg && (any_fail_reg || ch_bad);
	wire            ver_done = finish && !job_conf_reg && !job_mask_reg;
	wire [EV_W-1:0] ev_set   = {ver_done, conf_bad};

	wire [FAIL_W-1:0] fcount;
	wire [CH_W-1:0]   fail_ch;
	// entry index counts from the first failure slot, not from address zero
	wire [7:0]        fail_off = s_axi_araddr - OFF_FAIL0;
	wire [3:0]        fail_idx = fail_off[5:2];
	wire [CH_W-1:0]   relay_ch;

	rsv_mask_store u_masks (
		.clk_in         (clk_in),
		.reset_in       (reset_in),
		.wr_in          (scan && job_mask_reg),
		.wr_ch_in       (ch_reg),
		.wr_val_in      (job_val_reg),
		.save_in        (cmd_save),
		.recall_in      (cmd_recall),
		.auto_recall_in (auto_rcl_reg),
		.rd_ch_in       (sel_ch),
		.rd_val_out     (sel_mask)
	);

	rsv_fail_log u_fails (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.clear_in  (cmd_verify),
		.push_in   (ch_bad && !job_conf_reg),
		.ch_in     (ch_reg),
		.rd_idx_in (fail_idx),
		.count_out (fcount),
		.rd_ch_out (fail_ch)
	);

	// failure entry packs module in the upper half, channel in the lower half
	assign relay_ch = fail_ch;
	wire [31:0] fail_word = {8'h00, 8'(relay_ch / CH_W'(CH_PER_MOD)), 8'h00,
	                         8'(relay_ch % CH_W'(CH_PER_MOD))};
	wire [31:0] relay_word = relay_cmd_in[s_axi_araddr[2 +: 3] * 32 +: 32];

	wire rd_fail  = (s_axi_araddr >= OFF_FAIL0) &&
	                (s_axi_araddr < OFF_FAIL0 + 8'(4 * MAX_FAIL));
	wire rd_relay = (s_axi_araddr >= OFF_RELAY0) &&
	                (s_axi_araddr < OFF_RELAY0 + 8'(4 * WORDS));
	wire in_fail  = rd_fail && (fail_idx < 4'(fcount));
	wire [31:0] rd_mux =
		(s_axi_araddr == OFF_CTRL)     ? {30'h0, auto_rcl_reg, conf_en_reg} :
		(s_axi_araddr == OFF_STATUS)   ? {29'h0, ver_ok_reg, conf_fail_reg, busy} :
		(s_axi_araddr == OFF_IRQ_STAT) ? {30'h0, ev_stat_reg} :
		(s_axi_araddr == OFF_IRQ_MASK) ? {30'h0, ev_mask_reg} :
		(s_axi_araddr == OFF_RANGE)    ? {16'h0, last_reg, first_reg} :
		(s_axi_araddr == OFF_FCOUNT)   ? {28'h0, fcount} :
		(s_axi_araddr == OFF_MASKRD)   ? {22'h0, sel_mask, mask_rd_ch_reg} :
		in_fail                        ? fail_word :
		rd_relay                       ? relay_word : 32'h0;
	wire rd_known = (s_axi_araddr[7:2] <= OFF_MASKRD[7:2]) || rd_fail || rd_relay;

	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready  = !w_have_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign irq_out       = |(ev_stat_reg & ev_mask_reg);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_known ? AXI_OKAY : AXI_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= AXI_OKAY;
		end else if (do_read) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_mux;
			rresp_reg  <= rd_known ? AXI_OKAY : AXI_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			conf_en_reg    <= 1'b0;
			auto_rcl_reg   <= 1'b0;
			ev_mask_reg    <= '0;
			first_reg      <= '0;
			last_reg       <= '0;
			mask_rd_ch_reg <= '0;
		end else begin
			if (wr_ctrl) begin
				conf_en_reg  <= wdata_reg[CTRL_CONF];
				auto_rcl_reg <= wdata_reg[CTRL_AUTORCL];
			end
			if (wr_imask) begin
				ev_mask_reg <= wdata_reg[EV_W-1:0];
			end
			if (wr_range) begin
				first_reg <= wdata_reg[7:0];
				last_reg  <= wdata_reg[15:8];
			end
			if (wr_mrd) begin
				mask_rd_ch_reg <= wdata_reg[7:0];
			end
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ev_stat_reg <= '0;
		end else begin
			ev_stat_reg <= (ev_stat_reg & ~(wr_istat ? wdata_reg[EV_W-1:0] : '0)) | ev_set;
		end
	end

	// a relay change arriving mid-scan is remembered and checked after
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg     <= RSV_IDLE;
			job_conf_reg  <= 1'b0;
			job_mask_reg  <= 1'b0;
			job_val_reg   <= MASK_IGNORE;
			ch_reg        <= '0;
			end_reg       <= '0;
			any_fail_reg  <= 1'b0;
			conf_pend_reg <= 1'b0;
			conf_fail_reg <= 1'b0;
			ver_ok_reg    <= 1'b0;
		end else begin
			if (relay_change_in && conf_en_reg) begin
				conf_pend_reg <= 1'b1;
			end else if (start_conf) begin
				conf_pend_reg <= 1'b0;
			end
			case (state_reg)
				RSV_IDLE: begin
					any_fail_reg <= 1'b0;
					if (cmd_mask || cmd_verify) begin
						state_reg    <= RSV_SCAN;
						job_conf_reg <= 1'b0;
						job_mask_reg <= cmd_mask;
						job_val_reg  <= (cmd_val == 2'h3) ? MASK_IGNORE : cmd_val;
						ch_reg       <= first_reg;
						end_reg      <= last_reg;
					end else if (start_conf) begin
						state_reg    <= RSV_SCAN;
						job_conf_reg <= 1'b1;
						job_mask_reg <= 1'b0;
						ch_reg       <= '0;
						end_reg      <= CH_W'(NUM_CH - 1);
					end
				end
				RSV_SCAN: begin
					any_fail_reg <= any_fail_reg || ch_bad;
					if (at_end) begin
						state_reg <= RSV_DONE;
					end else begin
						ch_reg <= step_ch;
					end
					if (finish && job_conf_reg) begin
						conf_fail_reg <= any_fail_reg || ch_bad;
					end
					if (ver_done) begin
						ver_ok_reg <= !(any_fail_reg || ch_bad);
					end
				end
				RSV_DONE: begin
					state_reg <= RSV_IDLE;
				end
				default: begin
					state_reg <= RSV_IDLE;
				end
			endcase
		end
	end
endmodule

// ### tb/rsv_props.sv
// bus and interrupt checks on the verifier's top ports.
// assumes write address and data are offered together.
`timescale 1ns/1ps
module rsv_props
	import rsv_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        irq_out
);
	logic [7:0] rd_q;
	logic [7:0] ch_q;
	logic       cmd_seen;
	wire        aw_go = s_axi_awvalid && s_axi_awready;
	wire        hole  = (rd_q >= 8'h80) || (rd_q >= 8'h48 && rd_q < 8'h60);
	wire        mrd   = s_axi_rvalid && rd_q == OFF_MASKRD;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_q     <= 8'h00;
			ch_q     <= 8'h00;
			cmd_seen <= 1'b0;
		end else begin
			if (s_axi_arvalid && s_axi_arready)
				rd_q <= s_axi_araddr;
			if (aw_go && s_axi_awaddr == OFF_MASKRD)
				ch_q <= s_axi_wdata[7:0];
			if (aw_go && s_axi_awaddr == OFF_CMD)
				cmd_seen <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_write_answer: assert property (aw_go |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered in two cycles");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_hole_error: assert property (s_axi_rvalid |->
		s_axi_rresp == (hole ? AXI_SLVERR : AXI_OKAY) && (!hole || s_axi_rdata == 32'h0))
		else $error("wrong response for address");
	a_mask_echo: assert property (mrd |-> s_axi_rdata[7:0] == ch_q && s_axi_rdata[31:10] == 22'h0)
		else $error("mask readback names wrong channel");
	a_mask_default: assert property (mrd && !cmd_seen |-> s_axi_rdata[9:8] == MASK_IGNORE)
		else $error("mask not ignore before any write");
	a_fail_limit: assert property (s_axi_rvalid && rd_q == OFF_FCOUNT |-> s_axi_rdata <= 32'ha)
		else $error("failure count above ten");
	a_reset_quiet: assert property ($fell(reset_in) |-> !irq_out && !s_axi_bvalid && !s_axi_rvalid)
		else $error("activity right after reset");

	c_irq: cover property ($rose(irq_out));
	c_mask: cover property (mrd);
	c_hole: cover property (s_axi_rvalid && hole);
endmodule

// ### tb/rsv_card_model.sv
// relay card model: one readback line per relay, open-drain drivers.
// assumes fault_in marks relays whose coil or driver has failed.
`timescale 1ns/1ps
module rsv_card_model
	import rsv_pkg::*;
(
	input  wire logic [NUM_CH-1:0] relay_cmd_in,
	input  wire logic [NUM_CH-1:0] fault_in,
	output logic      [NUM_CH-1:0] readback_out
);
	// an on driver pulls its line low, so software must pick inverted masks
	assign readback_out = ~(relay_cmd_in ^ fault_in);
endmodule

// ### tb/rsv_top_tb_top.sv
// self-checking bench for the relay state verifier.
// assumes a card whose drivers pull readback low when a relay is on.
`timescale 1ns/1ps
module rsv_top_tb_top
	import rsv_pkg::*;
;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] val;
		logic [1:0]  resp;
	} rsv_row_s;

	logic              clk_in;
	logic              reset_in      = 1'b1;
	logic [NUM_CH-1:0] relay_cmd     = {8{32'hc3c35a5a}};
	logic [NUM_CH-1:0] fault         = '0;
	logic [NUM_CH-1:0] readback;
	logic              relay_change  = 1'b0;
	logic [7:0]        s_axi_awaddr  = 8'h00;
	logic              s_axi_awvalid = 1'b0;
	logic              s_axi_awready;
	logic [31:0]       s_axi_wdata   = 32'h0;
	logic              s_axi_wvalid  = 1'b0;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready  = 1'b0;
	logic [7:0]        s_axi_araddr  = 8'h00;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready  = 1'b0;
	logic              irq_out;
	logic [31:0]       d;
	logic [1:0]        r;
	int                checked       = 0;
	int                err_total     = 0;
	// reset values, relay word and two unmapped places
	rsv_row_s          rows [8]      = '{
		'{OFF_CTRL, 32'h0, AXI_OKAY}, '{OFF_STATUS, 32'h0, AXI_OKAY},
		'{OFF_IRQ_STAT, 32'h0, AXI_OKAY}, '{OFF_IRQ_MASK, 32'h0, AXI_OKAY},
		'{OFF_FCOUNT, 32'h0, AXI_OKAY}, '{OFF_RELAY0, 32'hc3c35a5a, AXI_OKAY},
		'{8'h50, 32'h0, AXI_SLVERR}, '{8'hfc, 32'h0, AXI_SLVERR}};

	rsv_card_model card (.relay_cmd_in(relay_cmd), .fault_in(fault), .readback_out(readback));

	rsv_top uut (
		.clk_in(clk_in), .reset_in(reset_in), .relay_cmd_in(relay_cmd),
		.readback_in(readback), .relay_change_in(relay_change),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// handshakes are judged on values settled before the edge, never in the edge's own step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int   n;
		logic aw_t;
		logic w_t;
		logic b_t;
		@(posedge clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_in);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t  = s_axi_wvalid && s_axi_wready;
			b_t  = s_axi_bvalid;
			@(posedge clk_in);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			n++;
		end while (!b_t && n < 300);
		if (!b_t) err_total++;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int   n;
		logic ar_t;
		logic r_t;
		@(posedge clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_in);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t  = s_axi_rvalid;
			d    = s_axi_rdata;
			r    = s_axi_rresp;
			@(posedge clk_in);
			if (ar_t) s_axi_arvalid <= 1'b0;
			n++;
		end while (!r_t && n < 300);
		if (!r_t) err_total++;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask

	task automatic mchk(input logic [7:0] ch, input logic [1:0] m);
		wr(OFF_MASKRD, {24'h0, ch});
		rchk(OFF_MASKRD, {22'h0, m, ch});
	endtask

	// irq is combinational of registers that land at the edge, so look mid-cycle
	task automatic ichk(input logic e);
		@(negedge clk_in);
		chk({31'h0, irq_out}, {31'h0, e});
	endtask

	task automatic idle;
		int n;
		n = 0;
		do begin
			rd(OFF_STATUS);
			n++;
		end while (d[ST_BUSY] !== 1'b0 && n < 400);
	endtask

	task automatic run(input logic [31:0] rg, input logic [31:0] c);
		wr(OFF_RANGE, rg);
		wr(OFF_CMD, c);
		idle;
	endtask

	task automatic pulse;
		@(posedge clk_in);
		relay_change <= 1'b1;
		@(posedge clk_in);
		relay_change <= 1'b0;
		idle;
	endtask

	task automatic close_out;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		close_out;
	end

	initial begin
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(rows[i].addr);
			chk(d, rows[i].val);
			chk({30'h0, r}, {30'h0, rows[i].resp});
		end
		mchk(8'h05, MASK_IGNORE);
		for (int v = 0; v < 3; v++) begin
			run({16'h0, 8'(8'h60 + v), 8'(8'h60 + v)}, 32'(v * 16 + 1));
			mchk(8'(8'h60 + v), 2'(v));
		end
		run(32'h0000404a, 32'h11);
		mchk(8'h40, MASK_INVERT);
		mchk(8'h4a, MASK_INVERT);
		mchk(8'h4b, MASK_IGNORE);
		run(32'h00004a40, 32'h2);
		rchk(OFF_STATUS, 32'h4);
		rchk(OFF_FCOUNT, 32'h0);
		fault[8'h43] <= 1'b1;
		fault[8'h45] <= 1'b1;
		fault[8'h4b] <= 1'b1;
		run(32'h00004b40, 32'h2);
		rchk(OFF_FCOUNT, 32'h2);
		rchk(OFF_FAIL0, 32'h00020003);
		rchk(OFF_FAIL0 + 8'h4, 32'h00020005);
		rchk(OFF_STATUS, 32'h0);
		run(32'h00008f80, 32'h11);
		fault[143:128] <= 16'hffff;
		run(32'h00008f80, 32'h2);
		rchk(OFF_FCOUNT, 32'ha);
		rchk(OFF_FAIL0 + 8'h24, 32'h00040009);
		run(32'h00006260, 32'h2);
		rchk(OFF_FCOUNT, 32'h1);
		rchk(OFF_FAIL0, 32'h00030000);
		wr(OFF_IRQ_MASK, 32'h1);
		rchk(OFF_IRQ_STAT, 32'h2);
		ichk(1'b0);
		wr(OFF_IRQ_MASK, 32'h3);
		ichk(1'b1);
		wr(OFF_IRQ_STAT, 32'h2);
		ichk(1'b0);
		run(32'h0, 32'h4);
		run(32'h00004040, 32'h21);
		mchk(8'h40, MASK_IGNORE);
		run(32'h0, 32'h8);
		mchk(8'h40, MASK_INVERT);
		fault <= '0;
		run(32'h00006060, 32'h21);
		pulse;
		rchk(OFF_IRQ_STAT, 32'h0);
		wr(OFF_CTRL, 32'h1);
		pulse;
		rchk(OFF_STATUS, 32'h0);
		fault[8'h43] <= 1'b1;
		pulse;
		rchk(OFF_STATUS, 32'h2);
		rchk(OFF_IRQ_STAT, 32'h1);
		ichk(1'b1);
		rchk(OFF_FCOUNT, 32'h1);
		close_out;
	end
endmodule

bind rsv_top rsv_props chk_i (
	.clk_in(clk_in), .reset_in(reset_in), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out));
